// ==== hdl/cmul_pkg.sv ====
/*
 constants, field layouts, register offsets and mode codes of the complex multiplier
 in the pre-processing stage; assumes a 40 MHz single clock and an APB register bus.
*/
// Functional notes
// - mode 000b bypasses the multiplier, samples pass unmodified
// - mode 001b multiplies sample n by twiddle index n times phase step, 16384 entries
// - mode 010b shifts frequency and advances it at every iteration end
// - exactly one complex multiply per clock in every mode except bypass and magnitude squared
// - slow DFT first iteration frequency equals the phase step
// - DFT increment is two to the (14 minus size code), code at most 1110b
// - iteration k index is (phase step plus increment times k) times n modulo 16384
// - mode 011b stitching pattern: step LSBs 00b 2K, 01b 4K, others reserved
// - mode 100b outputs each sample's magnitude squared
// - mode 101b multiplies by one 21-bit complex constant from common registers
// - scalar constant is the same for every iteration
// - mode 110b multiplies by successive RAM entries, read address resets per iteration
// - mode 111b like 110b but read address continues across iterations
// - vector RAM holds 512 complex entries
// - a 1024-point FFT overwrites the vector RAM, smaller FFTs leave it intact
// - coefficient writes go to window RAM when select is 0, else vector RAM
// - window start offset always refers to the window RAM
package cmul_pkg;
    typedef enum logic [2:0] {
        MODE_BYPASS = 3'b000,
        MODE_FREQ   = 3'b001,
        MODE_DFT    = 3'b010,
        MODE_STITCH = 3'b011,
        MODE_MAGSQ  = 3'b100,
        MODE_SCALAR = 3'b101,
        MODE_VEC1   = 3'b110,
        MODE_VEC2   = 3'b111
    } cmul_mode_t;

    localparam int          SAMPLE_W      = 24;
    localparam int          COEF_W        = 21;
    localparam int          LUT_IDX_W     = 14;
    localparam int          VEC_DEPTH     = 512;
    localparam int          VEC_ADDR_W    = 9;
    localparam int          COEF_FRAC     = 20;
    localparam int          MAG_SHIFT     = 23;
    localparam int          VEC_EXT_SHIFT = 5;
    localparam logic [3:0]  SIZE_CODE_MAX = 4'hE;
    localparam logic [3:0]  SIZE_CODE_FFT1K = 4'hA;
    localparam logic [3:0]  LUT_LOG2      = 4'hE;
    localparam logic [1:0]  STITCH_2K     = 2'h0;
    localparam logic [1:0]  STITCH_4K     = 2'h1;
    localparam logic [13:0] STITCH_STEP_2K = 14'h0008;
    localparam logic [13:0] STITCH_STEP_4K = 14'h0004;

    localparam logic [15:0] A_MODE        = 16'h0000;
    localparam logic [15:0] A_PHASE_STEP  = 16'h0004;
    localparam logic [15:0] A_SIZE_CODE   = 16'h0008;
    localparam logic [15:0] A_SCALAR_RE   = 16'h000C;
    localparam logic [15:0] A_SCALAR_IM   = 16'h0010;
    localparam logic [15:0] A_RAM_SELECT  = 16'h0014;
    localparam logic [15:0] A_STATUS      = 16'h0018;
    localparam logic [15:0] A_WIN_START   = 16'h001C;
    localparam int          COEF_SPACE_BIT = 12;
    localparam int          STATUS_VADDR_LSB = 16;
endpackage

// ==== hdl/complex_multiplier_preproc.sv ====
/*
 complex multiplier of the pre-processing stage: one complex multiply per clock on a
 sample stream, mode and coefficient registers over APB, internal 512-entry vector RAM.
 assumes an external twiddle LUT that answers combinationally to TWID_INDEX_O, an external
 window RAM write port, and an upstream formatter that marks iteration ends with IN_LAST_I.
*/
// The register addresses and the APB slave port were left to the implementer.
module complex_multiplier_preproc
    import cmul_pkg::*;
(
    input  wire logic                  CLOCK_I,
    input  wire logic                  RST_I,
    input  wire logic                  PSEL_I,
    input  wire logic                  PENABLE_I,
    input  wire logic                  PWRITE_I,
    input  wire logic [15:0]           PADDR_I,
    input  wire logic [31:0]           PWDATA_I,
    output logic      [31:0]           PRDATA_O,
    output logic                       PREADY_O,
    output logic                       PSLVERR_O,
    input  wire logic                  START_I,
    input  wire logic                  IN_VALID_I,
    input  wire logic                  IN_LAST_I,
    input  wire logic [SAMPLE_W-1:0]   IN_I_I,
    input  wire logic [SAMPLE_W-1:0]   IN_Q_I,
    output logic      [LUT_IDX_W-1:0]  TWID_INDEX_O,
    input  wire logic [COEF_W-1:0]     TWID_COS_I,
    input  wire logic [COEF_W-1:0]     TWID_SIN_I,
    output logic                       OUT_VALID_O,
    output logic                       OUT_LAST_O,
    output logic      [SAMPLE_W-1:0]   OUT_I_O,
    output logic      [SAMPLE_W-1:0]   OUT_Q_O,
    output logic                       WIN_WE_O,
    output logic      [9:0]            WIN_ADDR_O,
    output logic      [31:0]           WIN_DATA_O,
    output logic      [9:0]            WIN_START_O,
    input  wire logic                  FFT_RAM_WE_I,
    input  wire logic [VEC_ADDR_W-1:0] FFT_RAM_ADDR_I,
    input  wire logic [31:0]           FFT_RAM_DATA_I
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        cmul_mode_t           mode;
        logic [13:0]          phase_step;
        logic [3:0]           size_code;
        logic [COEF_W-1:0]    scal_re;
        logic [COEF_W-1:0]    scal_im;
        logic                 ram_sel;
        logic [9:0]           win_start;
        logic [13:0]          freq;
        logic [13:0]          acc;
        logic [11:0]          n;
        logic [9:0]           iter;
        logic [VEC_ADDR_W-1:0] vaddr;
        logic                 s1_valid;
        logic                 s1_last;
        cmul_mode_t           s1_mode;
        logic [SAMPLE_W-1:0]  s1_i;
        logic [SAMPLE_W-1:0]  s1_q;
        logic [13:0]          s1_tidx;
        logic                 out_valid;
        logic                 out_last;
        logic [SAMPLE_W-1:0]  out_i;
        logic [SAMPLE_W-1:0]  out_q;
        logic [31:0]          rdata;
        logic                 slverr;
    } state_t;

    state_t            st_r;
    state_t            st_nxt;
    logic [31:0]       vec_mem [VEC_DEPTH];
    logic [31:0]       vec_q_r;
    logic              apb_setup;
    logic              apb_wr;
    logic              coef_hit;
    logic              vec_host_we;

    localparam logic signed [47:0] SAT_MAX = 48'sh0000007FFFFF;
    localparam logic signed [47:0] SAT_MIN = -48'sh000000800000;

    function automatic logic [SAMPLE_W-1:0] sat24(input logic signed [47:0] v);
        logic [SAMPLE_W-1:0] res;
        if (v > SAT_MAX)
        begin
            res = SAT_MAX[SAMPLE_W-1:0];
        end
        else if (v < SAT_MIN)
        begin
            res = SAT_MIN[SAMPLE_W-1:0];
        end
        else
        begin
            res = v[SAMPLE_W-1:0];
        end
        return res;
    endfunction

    // ************************************************************
    // apb decode
    // ************************************************************
    assign apb_setup   = PSEL_I && !PENABLE_I;
    assign apb_wr      = PSEL_I && PENABLE_I && PWRITE_I;
    assign coef_hit    = PADDR_I[COEF_SPACE_BIT] && (PADDR_I[15:COEF_SPACE_BIT+1] == '0);
    assign vec_host_we = apb_wr && coef_hit && st_r.ram_sel;

    // write data travels straight to the window RAM; only the select bit steers it
    assign WIN_WE_O    = apb_wr && coef_hit && !st_r.ram_sel;
    assign WIN_ADDR_O  = PADDR_I[11:2];
    assign WIN_DATA_O  = PWDATA_I;
    assign WIN_START_O = st_r.win_start;
    assign PREADY_O    = PSEL_I && PENABLE_I;
    assign PRDATA_O    = st_r.rdata;
    assign PSLVERR_O   = PSEL_I && PENABLE_I && st_r.slverr;

    assign TWID_INDEX_O = st_r.s1_tidx;
    assign OUT_VALID_O  = st_r.out_valid;
    assign OUT_LAST_O   = st_r.out_last;
    assign OUT_I_O      = st_r.out_i;
    assign OUT_Q_O      = st_r.out_q;

    // ************************************************************
    // vector RAM
    // ************************************************************
    // 1024-point fft scratch writes win over a host write to the same cycle; the fft owns the RAM then
    always_ff @(posedge CLOCK_I)
    begin
        if (FFT_RAM_WE_I && (st_r.size_code == SIZE_CODE_FFT1K))
        begin
            vec_mem[FFT_RAM_ADDR_I] <= FFT_RAM_DATA_I;
        end
        else if (vec_host_we)
        begin
            vec_mem[PADDR_I[VEC_ADDR_W+1:2]] <= PWDATA_I;
        end
        vec_q_r <= vec_mem[st_r.vaddr];
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        logic        [13:0]       inc;
        logic        [13:0]       sstep;
        logic        [13:0]       tidx;
        logic signed [COEF_W-1:0] c;
        logic signed [COEF_W-1:0] d;
        logic signed [SAMPLE_W-1:0] a;
        logic signed [SAMPLE_W-1:0] b;
        logic signed [47:0]       re;
        logic signed [47:0]       im;
        logic signed [48:0]       mag;
        inc   = '0;
        sstep = '0;
        tidx  = '0;
        c     = '0;
        d     = '0;
        a     = '0;
        b     = '0;
        re    = '0;
        im    = '0;
        mag   = '0;
        st_nxt = st_r;

        // register reads are captured in the setup phase so PRDATA comes from a flop
        if (apb_setup)
        begin
            st_nxt.rdata  = '0;
            st_nxt.slverr = 1'b0;
            if (coef_hit)
            begin
                if (st_r.ram_sel)
                begin
                    st_nxt.rdata = vec_mem[PADDR_I[VEC_ADDR_W+1:2]];
                end
            end
            else if (PADDR_I == A_MODE)
            begin
                st_nxt.rdata = 32'(st_r.mode);
            end
            else if (PADDR_I == A_PHASE_STEP)
            begin
                st_nxt.rdata = 32'(st_r.phase_step);
            end
            else if (PADDR_I == A_SIZE_CODE)
            begin
                st_nxt.rdata = 32'(st_r.size_code);
            end
            else if (PADDR_I == A_SCALAR_RE)
            begin
                st_nxt.rdata = 32'(st_r.scal_re);
            end
            else if (PADDR_I == A_SCALAR_IM)
            begin
                st_nxt.rdata = 32'(st_r.scal_im);
            end
            else if (PADDR_I == A_RAM_SELECT)
            begin
                st_nxt.rdata = 32'(st_r.ram_sel);
            end
            else if (PADDR_I == A_STATUS)
            begin
                st_nxt.rdata = 32'(st_r.freq) | (32'(st_r.vaddr) << STATUS_VADDR_LSB);
            end
            else if (PADDR_I == A_WIN_START)
            begin
                st_nxt.rdata = 32'(st_r.win_start);
            end
            else
            begin
                st_nxt.slverr = 1'b1;
            end
        end

        if (apb_wr && !coef_hit)
        begin
            if (PADDR_I == A_MODE)
            begin
                st_nxt.mode = cmul_mode_t'(PWDATA_I[2:0]);
            end
            else if (PADDR_I == A_PHASE_STEP)
            begin
                st_nxt.phase_step = PWDATA_I[13:0];
            end
            else if (PADDR_I == A_SIZE_CODE)
            begin
                st_nxt.size_code = PWDATA_I[3:0];
            end
            else if (PADDR_I == A_SCALAR_RE)
            begin
                st_nxt.scal_re = PWDATA_I[COEF_W-1:0];
            end
            else if (PADDR_I == A_SCALAR_IM)
            begin
                st_nxt.scal_im = PWDATA_I[COEF_W-1:0];
            end
            else if (PADDR_I == A_RAM_SELECT)
            begin
                st_nxt.ram_sel = PWDATA_I[0];
            end
            else if (PADDR_I == A_WIN_START)
            begin
                st_nxt.win_start = PWDATA_I[9:0];
            end
        end

        // codes above the largest allowed one fall back to the finest step
        if (st_r.size_code > SIZE_CODE_MAX)
        begin
            inc = 14'h0001;
        end
        else
        begin
            inc = 14'h0001 << (LUT_LOG2 - st_r.size_code);
        end
        sstep = (st_r.phase_step[1:0] == STITCH_4K) ? STITCH_STEP_4K : STITCH_STEP_2K;

        // ---- stage 1: lut index and sample register ----
        case (st_r.mode)
            MODE_FREQ:   tidx = st_r.acc;
            MODE_DFT:    tidx = st_r.acc;
            MODE_STITCH:
            begin
                // reserved step codes read twiddle index zero, i.e. unity
                if (st_r.phase_step[1:0] == STITCH_2K)
                begin
                    tidx = 14'(14'(st_r.n[0]) * 14'(st_r.iter) * sstep);
                end
                else if (st_r.phase_step[1:0] == STITCH_4K)
                begin
                    tidx = 14'(14'(st_r.n[1:0]) * 14'(st_r.iter) * sstep);
                end
            end
            default:     tidx = '0;
        endcase

        st_nxt.s1_valid = IN_VALID_I;
        if (IN_VALID_I)
        begin
            st_nxt.s1_last = IN_LAST_I;
            st_nxt.s1_mode = st_r.mode;
            st_nxt.s1_i    = IN_I_I;
            st_nxt.s1_q    = IN_Q_I;
            st_nxt.s1_tidx = tidx;
            // 14-bit accumulator wraps, giving the index modulo the table length
            st_nxt.acc   = st_r.acc + ((st_r.mode == MODE_DFT) ? st_r.freq : st_r.phase_step);
            st_nxt.n     = st_r.n + 12'h001;
            st_nxt.vaddr = st_r.vaddr + 9'h001;
            if (IN_LAST_I)
            begin
                st_nxt.acc  = '0;
                st_nxt.n    = '0;
                st_nxt.iter = st_r.iter + 10'h001;
                if (st_r.mode == MODE_DFT)
                begin
                    st_nxt.freq = st_r.freq + inc;
                end
                if (st_r.mode == MODE_VEC1)
                begin
                    st_nxt.vaddr = '0;
                end
                // vector mode 2 keeps the advanced address into the next iteration
            end
        end

        if (START_I)
        begin
            st_nxt.freq  = st_r.phase_step;
            st_nxt.acc   = '0;
            st_nxt.n     = '0;
            st_nxt.iter  = '0;
            st_nxt.vaddr = '0;
        end

        // ---- stage 2: one complex multiplier shared by all modes but bypass and magnitude squared, which has its own squares ----
        a = st_r.s1_i;
        b = st_r.s1_q;
        case (st_r.s1_mode)
            MODE_SCALAR:
            begin
                c = st_r.scal_re;
                d = st_r.scal_im;
            end
            MODE_VEC1, MODE_VEC2:
            begin
                c = COEF_W'($signed(vec_q_r[15:0])) <<< VEC_EXT_SHIFT;
                d = COEF_W'($signed(vec_q_r[31:16])) <<< VEC_EXT_SHIFT;
            end
            default:
            begin
                c = TWID_COS_I;
                d = TWID_SIN_I;
            end
        endcase
        re  = (48'(a * c) - 48'(b * d)) >>> COEF_FRAC;
        im  = (48'(a * d) + 48'(b * c)) >>> COEF_FRAC;
        mag = (49'(a * a) + 49'(b * b)) >>> MAG_SHIFT;

        st_nxt.out_valid = st_r.s1_valid;
        st_nxt.out_last  = st_r.s1_valid && st_r.s1_last;
        if (st_r.s1_valid)
        begin
            if (st_r.s1_mode == MODE_BYPASS)
            begin
                st_nxt.out_i = st_r.s1_i;
                st_nxt.out_q = st_r.s1_q;
            end
            else if (st_r.s1_mode == MODE_MAGSQ)
            begin
                st_nxt.out_i = sat24(48'(mag));
                st_nxt.out_q = '0;
            end
            else
            begin
                st_nxt.out_i = sat24(re);
                st_nxt.out_q = sat24(im);
            end
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge CLOCK_I)
    begin
        if (RST_I)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
endmodule

// ==== verification/cmul_chk.sv ====
/*
 port assertions of the complex multiplier
 assumes mode, step and select change only by APB writes
*/
module cmul_chk
    import cmul_pkg::*;
(
    input wire logic        CLOCK_I,
    input wire logic        RST_I,
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [15:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic        PSLVERR_O,
    input wire logic        START_I,
    input wire logic        IN_VALID_I,
    input wire logic        IN_LAST_I,
    input wire logic [23:0] IN_I_I,
    input wire logic [23:0] IN_Q_I,
    input wire logic [13:0] TWID_INDEX_O,
    input wire logic        OUT_VALID_O,
    input wire logic [23:0] OUT_Q_O,
    input wire logic [23:0] OUT_I_O,
    input wire logic        WIN_WE_O,
    input wire logic [9:0]  WIN_ADDR_O,
    input wire logic [31:0] WIN_DATA_O,
    input wire logic [9:0]  WIN_START_O
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************
    // register mirror
    // ****************
    logic [2:0]  mode_r;
    logic        sel_r;
    logic [13:0] step_r;
    logic [13:0] n_r;
    logic [13:0] idx_exp;
    logic        wr;
    logic        cw;
    logic        bad;
    assign wr = PSEL_I && PENABLE_I && PWRITE_I;
    assign cw = wr && PADDR_I[15:12] == 4'h1;
    assign bad = !(PADDR_I[15:12] == 4'h1 || (PADDR_I < 16'h0020 && PADDR_I[1:0] == 2'h0));
    assign idx_exp = step_r * n_r;
    always_ff @(posedge CLOCK_I)
    begin
        if (RST_I)
        begin
            mode_r <= 3'h0;
            sel_r  <= 1'h0;
            step_r <= 14'h0000;
            n_r    <= 14'h0000;
        end
        else
        begin
            if (wr && PADDR_I == A_MODE) mode_r <= PWDATA_I[2:0];
            if (wr && PADDR_I == A_PHASE_STEP) step_r <= PWDATA_I[13:0];
            if (wr && PADDR_I == A_RAM_SELECT) sel_r <= PWDATA_I[0];
            // sample index restarts with each parameter set and each iteration
            if (START_I || (IN_VALID_I && IN_LAST_I)) n_r <= 14'h0000;
            else if (IN_VALID_I) n_r <= n_r + 14'h0001;
        end
    end
    // ****************
    // assertions
    // ****************
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);
    sequence s_take;
        IN_VALID_I;
    endsequence
    sequence s_win_wr;
        wr && PADDR_I == A_WIN_START;
    endsequence
    AST_LATENCY: assert property (s_take |-> ##2 OUT_VALID_O)
        else $error("no output two cycles after a sample");
    AST_NO_EXTRA: assert property (OUT_VALID_O |-> $past(IN_VALID_I, 2))
        else $error("output without a sample");
    AST_BYPASS: assert property (s_take and mode_r == MODE_BYPASS |-> ##2
        (OUT_I_O == $past(IN_I_I, 2) && OUT_Q_O == $past(IN_Q_I, 2))) else $error("bypass altered sample");
    AST_MAGSQ: assert property (s_take and mode_r == MODE_MAGSQ |-> ##2 OUT_Q_O == 24'h000000)
        else $error("magnitude output has imaginary part");
    AST_FREQ_IDX: assert property (s_take and mode_r == MODE_FREQ |=> TWID_INDEX_O == $past(idx_exp))
        else $error("wrong twiddle index");
    AST_WIN_WE: assert property (cw && !sel_r |-> WIN_WE_O && WIN_ADDR_O == PADDR_I[11:2]
        && WIN_DATA_O == PWDATA_I) else $error("window write missing");
    AST_VEC_WE: assert property (WIN_WE_O |-> cw && !sel_r)
        else $error("window write while vector selected");
    AST_WIN_START: assert property (s_win_wr |=> WIN_START_O == $past(PWDATA_I[9:0]))
        else $error("window start not loaded");
    AST_WIN_HOLD: assert property (!(wr && PADDR_I == A_WIN_START) |=> $stable(WIN_START_O))
        else $error("window start changed");
    AST_SLVERR: assert property (PSEL_I && PENABLE_I |-> PSLVERR_O == bad)
        else $error("wrong slave error");
endmodule

bind complex_multiplier_preproc cmul_chk i_chk (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
    .PSLVERR_O(PSLVERR_O), .START_I(START_I), .IN_VALID_I(IN_VALID_I), .IN_LAST_I(IN_LAST_I),
    .IN_I_I(IN_I_I), .IN_Q_I(IN_Q_I), .TWID_INDEX_O(TWID_INDEX_O), .OUT_VALID_O(OUT_VALID_O),
    .OUT_Q_O(OUT_Q_O), .OUT_I_O(OUT_I_O), .WIN_WE_O(WIN_WE_O), .WIN_ADDR_O(WIN_ADDR_O),
    .WIN_START_O(WIN_START_O), .WIN_DATA_O(WIN_DATA_O));

// ==== verification/tb_complex_multiplier_preproc.sv ====
/*
 testbench: APB register tasks and single-sample stream tasks per mode
 assumes the table model answers combinationally and zero-wait APB
*/
module tb_complex_multiplier_preproc;
    import cmul_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'h0, rst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
    logic        start = 1'h0, vld = 1'h0, lst = 1'h0, fwe = 1'h0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0, fdata = 32'h0, prdata, wdata;
    logic [23:0] ii = 24'h0, qq = 24'h0, oi, oq;
    logic [8:0]  faddr = 9'h000;
    logic        pready, pslverr, ovld, olast, wwe;
    logic [13:0] tidx;
    logic [20:0] tcos, tsin, gc, gs;
    logic [9:0]  waddr, wstart;
    logic [31:0] ent [4];
    int          miscompares = 0, samples_checked = 0, cyc = 0, inc;
    always #12.5 clk = ~clk;
    complex_multiplier_preproc i_dut (.CLOCK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .START_I(start), .IN_VALID_I(vld), .IN_LAST_I(lst), .IN_I_I(ii),
        .IN_Q_I(qq), .TWID_INDEX_O(tidx), .TWID_COS_I(tcos), .TWID_SIN_I(tsin), .OUT_VALID_O(ovld),
        .OUT_LAST_O(olast), .OUT_I_O(oi), .OUT_Q_O(oq), .WIN_WE_O(wwe), .WIN_ADDR_O(waddr),
        .WIN_DATA_O(wdata), .WIN_START_O(wstart), .FFT_RAM_WE_I(fwe), .FFT_RAM_ADDR_I(faddr),
        .FFT_RAM_DATA_I(fdata));
    twid_lut_model i_lut (.idx_i(tidx), .cos_o(tcos), .sin_o(tsin));
    // ****************
    // tasks
    // ****************
    task automatic finish_test;
        if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc > 6000)
        begin
            miscompares++;
            finish_test;
        end
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    function automatic logic [23:0] sat(input longint v);
        if (v > 8388607) return 24'h7FFFFF;
        if (v < -8388608) return 24'h800000;
        return v[23:0];
    endfunction
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'h1; pen <= 1'h0; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'h1, a, d, r, e);
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] x, input logic [31:0] m, input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'h0, a, 32'h0, r, e);
        cmp(r & m, x);
        cmp({31'h0, e}, {31'h0, xe});
    endtask
    task automatic go;
        @(posedge clk);
        start <= 1'h1;
        @(posedge clk);
        start <= 1'h0;
    endtask
    // kind 0 passes through, 1 multiplies by table (idx >= 0) or gc/gs, 2 squares magnitude
    task automatic smp(input logic [23:0] i, input logic [23:0] q, input logic l, input int idx, input int k);
        logic [20:0] c;
        logic [20:0] s;
        longint      si, sq, sc, ss;
        logic [23:0] ei, eq;
        c = (idx >= 0) ? 21'h080000 : gc;
        s = (idx >= 0) ? 21'(idx) : gs;
        si = signed'(i); sq = signed'(q); sc = signed'(c); ss = signed'(s);
        ei = i;
        eq = q;
        if (k == 1) begin ei = sat((si * sc - sq * ss) >>> 20); eq = sat((si * ss + sq * sc) >>> 20); end
        if (k == 2) begin ei = sat((si * si + sq * sq) >>> 23); eq = 24'h000000; end
        @(posedge clk);
        vld <= 1'h1; ii <= i; qq <= q; lst <= l;
        @(posedge clk);
        vld <= 1'h0;
        lst <= 1'h0;
        #1;
        if (idx >= 0) cmp({18'h0, tidx}, 32'(idx));
        @(posedge clk);
        #1;
        cmp({31'h0, ovld}, 32'h1);
        cmp({8'h0, oi}, {8'h0, ei});
        cmp({8'h0, oq}, {8'h0, eq});
        cmp({31'h0, olast}, {31'h0, l});
    endtask
    task automatic vrun(input int j, input logic l);
        gc = {ent[j][15:0], 5'h00};
        gs = {ent[j][31:16], 5'h00};
        smp(24'h001000, 24'hFFF800, l, -1, 1);
    endtask
    task automatic fw(input logic [8:0] a, input logic [31:0] d);
        @(posedge clk);
        fwe <= 1'h1; faddr <= a; fdata <= d;
        @(posedge clk);
        fwe <= 1'h0;
    endtask
    // ****************
    // tests
    // ****************
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        rd(A_MODE, 32'h0, 32'hFFFFFFFF, 1'h0);
        rd(A_STATUS, 32'h0, 32'hFFFFFFFF, 1'h0);
        rd(16'h0020, 32'h0, 32'hFFFFFFFF, 1'h1);
        smp(24'h123456, 24'hFEDCBA, 1'h0, -1, 0);
        wr(A_MODE, MODE_FREQ);
        wr(A_PHASE_STEP, 32'h3001);
        go;
        for (int n = 0; n < 3; n++) smp(24'h001000, 24'hFFF800, n == 2, (n * 'h3001) % 16384, 1);
        wr(A_MODE, MODE_DFT);
        wr(A_PHASE_STEP, 32'h3);
        foreach (ent[c]) if (c < 2)
        begin
            inc = 1 << (c == 0 ? 3 : 0);
            wr(A_SIZE_CODE, c == 0 ? 32'hB : 32'hE);
            go;
            for (int k = 0; k < 2; k++)
                for (int n = 0; n < 3; n++)
                    smp(24'h001000, 24'hFFF800, n == 2, ((3 + inc * k) * n) % 16384, 1);
            rd(A_STATUS, 3 + 2 * inc, 32'h3FFF, 1'h0);
        end
        wr(A_MODE, MODE_STITCH);
        for (int p = 0; p < 2; p++)
        begin
            wr(A_PHASE_STEP, p);
            go;
            for (int k = 0; k < 2; k++)
                for (int n = 0; n < 4; n++)
                    smp(24'h001000, 24'hFFF800, n == 3, p == 1 ? (n % 4) * k * 4 : (n % 2) * k * 8, 1);
        end
        wr(A_MODE, MODE_MAGSQ);
        smp(24'h001000, 24'hFFF800, 1'h0, -1, 2);
        smp(24'h7FFFFF, 24'h800000, 1'h1, -1, 2);
        wr(A_SCALAR_RE, 32'h000C0000);
        wr(A_SCALAR_IM, 32'h001C0000);
        gc = 21'h0C0000;
        gs = 21'h1C0000;
        wr(A_MODE, MODE_SCALAR);
        go;
        repeat (2) smp(24'h001000, 24'hFFF800, 1'h1, -1, 1);
        wr(A_RAM_SELECT, 32'h1);
        for (int j = 0; j < 4; j++)
        begin
            ent[j] = {16'(j * 'h800), 16'((j + 1) * 'h1000)};
            wr(16'(16'h1000 + 4 * j), ent[j]);
        end
        wr(A_WIN_START, 32'h2A5);
        #1;
        cmp({22'h0, wstart}, 32'h2A5);
        wr(A_RAM_SELECT, 32'h0);
        wr(16'h1000, 32'h0);
        wr(A_MODE, MODE_VEC1);
        go;
        for (int k = 0; k < 2; k++) for (int n = 0; n < 2; n++) vrun(n, n == 1);
        wr(A_MODE, MODE_VEC2);
        go;
        for (int k = 0; k < 2; k++) for (int n = 0; n < 2; n++) vrun(2 * k + n, n == 1);
        rd(A_STATUS, 32'h00040000, 32'h01FF0000, 1'h0);
        wr(A_SIZE_CODE, SIZE_CODE_FFT1K);
        fw(9'h000, 32'h00002000);
        ent[0] = 32'h00002000;
        wr(A_SIZE_CODE, 32'h9);
        fw(9'h001, 32'h00000100);
        wr(A_MODE, MODE_VEC1);
        go;
        vrun(0, 1'h0);
        vrun(1, 1'h1);
        finish_test;
    end
endmodule

// ==== verification/twid_lut_model.sv ====
/*
 stand-in for the external twiddle table
 assumes the multiplier reads it combinationally
*/
module twid_lut_model
(
    input  wire logic [13:0] idx_i,
    output logic      [20:0] cos_o,
    output logic      [20:0] sin_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // half-scale cosine keeps products easy; sine follows the index so a bad index shows
    assign cos_o = 21'h080000;
    assign sin_o = {7'h00, idx_i};
endmodule
